// [core/ssc_device.sv]
// Serial shift port of the device: master or slave, one shift register.
// Assumes link pins synchronous to core_clk and a partner on ssc_link_if.
`include "ssc_cfg.svh"

module ssc_device #(
   parameter int CHAR_BITS  = `SSC_CHAR_BITS,
   parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 spi_en,
   input  wire logic                 master_mode,
   input  wire logic [15:0]          baud_div,
   input  wire logic [CHAR_BITS-1:0] tx_data,
   input  wire logic                 tx_valid,
   output logic                      tx_ready,
   output logic      [CHAR_BITS-1:0] rx_data,
   output logic                      rx_valid,
   input  wire logic                 rx_ready,
   output logic                      busy,
   ssc_link_if.dev                   link
);
   localparam int CNTW = (CHAR_BITS > 1) ? $clog2(CHAR_BITS) : 1;
   localparam logic [CNTW-1:0] LAST_BIT = CNTW'(CHAR_BITS - 1);

   // ==========================================================
   // Parameter check
   generate
      if (CHAR_BITS < 2) begin : g_bad
         $error("ssc_device: CHAR_BITS must be at least 2");
      end
   endgenerate

   ssc_pkg::ssc_state_type st_reg;
   logic [CHAR_BITS-1:0]   shreg_reg;
   logic                   sample_reg;
   logic [CNTW-1:0]        bit_cnt_reg;
   logic [15:0]            div_reg;
   logic                   sck_reg;
   logic                   ss_n_reg;
   logic                   rx_valid_reg;
   logic                   sck_prev_reg;

   logic [CHAR_BITS-1:0]   fifo_data;
   logic                   fifo_valid;
   logic                   fifo_ready;
   logic                   selected;
   logic                   as_master;
   logic                   as_slave;
   logic                   slave_on;
   logic                   m_tick;
   logic                   m_rise;
   logic                   m_fall;
   logic                   do_sample;
   logic                   do_shift;
   logic                   last;
   logic                   load;
   logic                   rx_take;
   logic [15:0]            half_reload;

   // ==========================================================
   // Transmit buffer
   // The buffer sits ahead of the shift register; the register itself
   // holds both outgoing and incoming bits
   ssc_fifo #(
      .WIDTH (CHAR_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   // ==========================================================
   // Role and event decode
   assign selected  = link.ss_n_line == `SSC_SS_ASSERTED;
   assign as_master = spi_en & master_mode;
   assign as_slave  = spi_en & ~master_mode;
   assign slave_on  = as_slave & selected & ~rx_valid_reg;
   assign m_tick    = div_reg == 16'h0000;
   assign m_rise    = as_master & (st_reg == ssc_pkg::SSC_SHIFT) & m_tick & ~sck_reg;
   assign m_fall    = as_master & (st_reg == ssc_pkg::SSC_SHIFT) & m_tick & sck_reg;
   assign do_sample = m_rise | (slave_on & link.sck_line & ~sck_prev_reg);
   assign do_shift  = m_fall | (slave_on & ~link.sck_line & sck_prev_reg);
   assign last      = do_shift & (bit_cnt_reg == LAST_BIT);
   assign load      = fifo_valid & ~rx_valid_reg & (st_reg == ssc_pkg::SSC_IDLE)
                      & (as_master | (as_slave & ~selected));
   assign fifo_ready = load;
   assign rx_take   = rx_valid_reg & rx_ready;
   // Zero divisor behaves as one so the clock never stalls
   assign half_reload = (baud_div == 16'h0000) ? 16'h0000 : baud_div - 16'h0001;

   // ==========================================================
   // Sequencing
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg <= ssc_pkg::SSC_IDLE;
      end else if (!spi_en) begin
         st_reg <= ssc_pkg::SSC_IDLE;
      end else if (load) begin
         st_reg <= ssc_pkg::SSC_SHIFT;
      end else if (last) begin
         st_reg <= ssc_pkg::SSC_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bit_cnt_reg <= '0;
      end else if (!spi_en || load || (as_slave && !selected)) begin
         // A slave deselected mid-character drops the partial count
         bit_cnt_reg <= '0;
      end else if (do_shift) begin
         bit_cnt_reg <= last ? '0 : bit_cnt_reg + 1'b1;
      end
   end

   // ==========================================================
   // Shift register
   // Sample then shift each bit
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sample_reg <= 1'b0;
      end else if (do_sample) begin
         sample_reg <= as_master ? link.miso_line : link.mosi_line;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         shreg_reg <= '0;
      end else if (load) begin
         shreg_reg <= fifo_data;
      end else if (do_shift) begin
         shreg_reg <= {shreg_reg[CHAR_BITS-2:0], sample_reg};
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_valid_reg <= 1'b0;
      end else if (last) begin
         // Completion wins over a read in the same cycle
         rx_valid_reg <= 1'b1;
      end else if (rx_take) begin
         rx_valid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Master clock generation
   // Divider paces clock edges
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (load || (st_reg == ssc_pkg::SSC_SHIFT && m_tick)) begin
         div_reg <= half_reload;
      end else if (st_reg == ssc_pkg::SSC_SHIFT) begin
         div_reg <= div_reg - 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sck_reg <= `SSC_SCK_IDLE;
      end else if (!as_master || load) begin
         sck_reg <= `SSC_SCK_IDLE;
      end else if (m_rise || m_fall) begin
         sck_reg <= ~sck_reg;
      end
   end

   // Select drops one cycle after the last fall: a slave sees the clock
   // a cycle late and must still be selected when it takes that edge
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ss_n_reg <= `SSC_SS_RELEASED;
      end else if (!as_master) begin
         ss_n_reg <= `SSC_SS_RELEASED;
      end else if (load) begin
         ss_n_reg <= `SSC_SS_ASSERTED;
      end else if (st_reg == ssc_pkg::SSC_IDLE) begin
         ss_n_reg <= `SSC_SS_RELEASED;
      end
   end

   // Edge history of the incoming clock; pins are already synchronous
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sck_prev_reg <= `SSC_SCK_IDLE;
      end else begin
         sck_prev_reg <= link.sck_line;
      end
   end

   // ==========================================================
   // Pin drive
   // Master drives clock and select
   assign link.dev_sck_o   = sck_reg;
   assign link.dev_sck_oe  = as_master;
   assign link.dev_ss_n_o  = ss_n_reg;
   assign link.dev_ss_n_oe = as_master;
   assign link.dev_mosi_o  = shreg_reg[CHAR_BITS-1];
   assign link.dev_mosi_oe = as_master;
   assign link.dev_miso_o  = shreg_reg[CHAR_BITS-1];
   assign link.dev_miso_oe = as_slave & selected;

   // ==========================================================
   // User side
   assign rx_data  = shreg_reg;
   assign rx_valid = rx_valid_reg;
   assign busy     = st_reg == ssc_pkg::SSC_SHIFT;
endmodule

// [common/ssc_cfg.svh]
// Fixed figures of the serial shift core: character size, buffer depth,
// timing limits and the resting levels of undriven link wires.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef SSC_CFG_SVH
`define SSC_CFG_SVH

`define SSC_CHAR_BITS      8
`define SSC_FIFO_DEPTH     32
`define SSC_CLK_PERIOD_NS  20
`define SSC_MIN_SCK_SYSCLK 8
`define SSC_LINE_IDLE      1'b1
`define SSC_SCK_IDLE       1'b0
`define SSC_SS_ASSERTED    1'b0
`define SSC_SS_RELEASED    1'b1

`endif

// [common/ssc_pkg.sv]
// Types shared by both ends of the serial shift core.
// Assumes nothing beyond a SystemVerilog compiler.
package ssc_pkg;

   // Transfer sequencing of either end
   typedef enum logic [1:0] {
      SSC_IDLE,
      SSC_SHIFT
   } ssc_state_type;

endpackage

// [common/ssc_link_if.sv]
// Four-wire serial link between the core and its partner.
// Each wire is resolved from the drive enables of both ends; an undriven
// wire rests at its idle level, as a pull resistor would hold it.
`include "ssc_cfg.svh"

interface ssc_link_if;
   logic dev_sck_o,  dev_sck_oe,  part_sck_o,  part_sck_oe;
   logic dev_mosi_o, dev_mosi_oe, part_mosi_o, part_mosi_oe;
   logic dev_miso_o, dev_miso_oe, part_miso_o, part_miso_oe;
   logic dev_ss_n_o, dev_ss_n_oe, part_ss_n_o, part_ss_n_oe;
   logic sck_line;
   logic mosi_line;
   logic miso_line;
   logic ss_n_line;

   // The device end wins a contention; the bench flags it on the clock wire only
   assign sck_line  = dev_sck_oe  ? dev_sck_o  : part_sck_oe  ? part_sck_o  : `SSC_SCK_IDLE;
   assign mosi_line = dev_mosi_oe ? dev_mosi_o : part_mosi_oe ? part_mosi_o : `SSC_LINE_IDLE;
   assign miso_line = dev_miso_oe ? dev_miso_o : part_miso_oe ? part_miso_o : `SSC_LINE_IDLE;
   assign ss_n_line = dev_ss_n_oe ? dev_ss_n_o : part_ss_n_oe ? part_ss_n_o : `SSC_SS_RELEASED;

   modport dev (
      output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
      output dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe,
      input  sck_line, mosi_line, miso_line, ss_n_line
   );
   modport part (
      output part_sck_o, part_sck_oe, part_mosi_o, part_mosi_oe,
      output part_miso_o, part_miso_oe, part_ss_n_o, part_ss_n_oe,
      input  sck_line, mosi_line, miso_line, ss_n_line
   );
endinterface

// [core/ssc_fifo.sv]
// Synchronous first-in first-out buffer with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
module ssc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   // ==========================================================
   // Parameter check
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
         $error("ssc_fifo: DEPTH must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      rd_ptr_reg;
   logic             push;
   logic             pop;

   // ==========================================================
   // Flags
   // Extra pointer bit tells full from empty without a counter
   assign in_ready  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr_reg != rd_ptr_reg;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];

   // ==========================================================
   // Storage and pointers
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
      end else if (push) begin
         wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rd_ptr_reg <= '0;
      end else if (pop) begin
         rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule

// [core/ssc_partner.sv]
// Far end of the link: a plain master or slave facing the device.
// Assumes link pins synchronous to core_clk and the device on ssc_link_if.
`include "ssc_cfg.svh"

module ssc_partner #(
   parameter int CHAR_BITS   = `SSC_CHAR_BITS,
   parameter int HALF_CYCLES = `SSC_MIN_SCK_SYSCLK / 2
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset_n,
   input  wire logic                 part_master,
   input  wire logic [CHAR_BITS-1:0] p_tx_data,
   input  wire logic                 p_tx_valid,
   output logic                      p_tx_ready,
   output logic      [CHAR_BITS-1:0] p_rx_data,
   output logic                      p_rx_valid,
   ssc_link_if.part                  link
);
   localparam int CNTW = (CHAR_BITS > 1) ? $clog2(CHAR_BITS) : 1;
   localparam int HW   = $clog2(HALF_CYCLES + 1);
   localparam logic [CNTW-1:0] LAST_BIT = CNTW'(CHAR_BITS - 1);
   localparam logic [HW-1:0]   HALF_RELOAD = HW'(HALF_CYCLES - 1);

   // ==========================================================
   // Parameter check
   generate
      if (2 * HALF_CYCLES < `SSC_MIN_SCK_SYSCLK || CHAR_BITS < 2) begin : g_bad
         $error("ssc_partner: serial clock period below the slave's minimum");
      end
   endgenerate

   ssc_pkg::ssc_state_type st_reg;
   logic [CHAR_BITS-1:0]   shreg_reg;
   logic [CNTW-1:0]        bit_cnt_reg;
   logic [HW-1:0]          div_reg;
   logic                   sck_reg;
   logic                   sample_reg;
   logic                   sck_prev_reg;
   logic                   rx_valid_reg;
   logic                   ss_hold_reg;
   logic                   selected;
   logic                   m_tick;
   logic                   in_shift;
   logic                   do_sample;
   logic                   do_shift;
   logic                   last;
   logic                   load;

   assign selected  = link.ss_n_line == `SSC_SS_ASSERTED;
   assign in_shift  = st_reg == ssc_pkg::SSC_SHIFT;
   assign m_tick    = div_reg == '0;
   assign do_sample = part_master ? (in_shift & m_tick & ~sck_reg)
                                  : (selected & link.sck_line & ~sck_prev_reg);
   assign do_shift  = part_master ? (in_shift & m_tick & sck_reg)
                                  : (selected & ~link.sck_line & sck_prev_reg);
   assign last      = do_shift & (bit_cnt_reg == LAST_BIT);
   assign load      = p_tx_valid & ~in_shift & (part_master | ~selected);
   assign p_tx_ready = ~in_shift & (part_master | ~selected);

   // ==========================================================
   // Sequencing and shifting
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st_reg <= ssc_pkg::SSC_IDLE;
      end else if (load) begin
         st_reg <= ssc_pkg::SSC_SHIFT;
      end else if (last) begin
         st_reg <= ssc_pkg::SSC_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         bit_cnt_reg <= '0;
      end else if (load || (!part_master && !selected)) begin
         bit_cnt_reg <= '0;
      end else if (do_shift) begin
         bit_cnt_reg <= last ? '0 : bit_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sample_reg <= 1'b0;
      end else if (do_sample) begin
         sample_reg <= part_master ? link.miso_line : link.mosi_line;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         shreg_reg <= '0;
      end else if (load) begin
         shreg_reg <= p_tx_data;
      end else if (do_shift) begin
         shreg_reg <= {shreg_reg[CHAR_BITS-2:0], sample_reg};
      end
   end

   // Received character leaves as a one-cycle strobe
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         rx_valid_reg <= 1'b0;
         p_rx_data    <= '0;
      end else begin
         rx_valid_reg <= last;
         if (last) begin
            p_rx_data <= {shreg_reg[CHAR_BITS-2:0], sample_reg};
         end
      end
   end

   // ==========================================================
   // Clock generation as master
   // Half period of HALF_CYCLES
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         div_reg <= '0;
      end else if (load || (in_shift && m_tick)) begin
         div_reg <= HALF_RELOAD;
      end else if (in_shift) begin
         div_reg <= div_reg - 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sck_reg <= `SSC_SCK_IDLE;
      end else if (!part_master || load) begin
         sck_reg <= `SSC_SCK_IDLE;
      end else if (in_shift && m_tick) begin
         sck_reg <= ~sck_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         sck_prev_reg <= `SSC_SCK_IDLE;
      end else begin
         sck_prev_reg <= link.sck_line;
      end
   end

   // Select stays low one cycle past the last fall so that a slave,
   // which sees the clock a cycle late, still takes its eighth edge
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         ss_hold_reg <= 1'b0;
      end else begin
         ss_hold_reg <= last & part_master;
      end
   end

   // ==========================================================
   // Pin drive
   assign p_rx_valid        = rx_valid_reg;
   assign link.part_sck_o   = sck_reg;
   assign link.part_sck_oe  = part_master;
   assign link.part_ss_n_o  = (in_shift | ss_hold_reg) ? `SSC_SS_ASSERTED : `SSC_SS_RELEASED;
   assign link.part_ss_n_oe = part_master;
   assign link.part_mosi_o  = shreg_reg[CHAR_BITS-1];
   assign link.part_mosi_oe = part_master;
   assign link.part_miso_o  = shreg_reg[CHAR_BITS-1];
   assign link.part_miso_oe = ~part_master & selected;
endmodule

// [sim/ssc_link_sva.sv]
// Checker of the four link wires between the two ends.
// Assumes it sits beside the link interface and sees its signals directly.
module ssc_link_sva (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic dev_sck_oe,
   input wire logic dev_mosi_oe,
   input wire logic dev_miso_oe,
   input wire logic part_sck_oe,
   input wire logic sck_line,
   input wire logic mosi_line,
   input wire logic miso_line,
   input wire logic ss_n_line
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Helper: clock rises seen in one frame
   logic [3:0] rise_cnt_reg;
   always_ff @(posedge core_clk) begin
      if (!reset_n) rise_cnt_reg <= 4'h0;
      else if ($fell(ss_n_line)) rise_cnt_reg <= 4'h0;
      else if ($rose(sck_line)) rise_cnt_reg <= rise_cnt_reg + 4'h1;
   end

   // ==========================================================
   // Properties
   property p_miso_in;  dev_sck_oe |-> !dev_miso_oe; endproperty
   property p_mosi_in;  dev_miso_oe |-> !dev_mosi_oe; endproperty
   property p_unsel;    !dev_sck_oe && ss_n_line && $past(ss_n_line) |-> !dev_miso_oe; endproperty
   property p_one_drv;  !(dev_sck_oe && part_sck_oe); endproperty
   property p_sel_clk;  $rose(sck_line) |-> !ss_n_line; endproperty
   property p_high_len; $rose(sck_line) |-> sck_line [*4]; endproperty
   property p_low_len;  $fell(sck_line) && !ss_n_line |-> !sck_line [*4]; endproperty
   property p_eight;    $rose(ss_n_line) |-> rise_cnt_reg == 4'h8; endproperty
   property p_stable;   sck_line && $past(sck_line) |-> $stable(mosi_line) && $stable(miso_line);
   endproperty

   a_miso_in:  assert property (p_miso_in)  else $error("master drives data-in line");
   a_mosi_in:  assert property (p_mosi_in)  else $error("slave drives data-out line");
   a_unsel:    assert property (p_unsel)    else $error("unselected slave drives");
   a_one_drv:  assert property (p_one_drv)  else $error("two clock drivers");
   a_sel_clk:  assert property (p_sel_clk)  else $error("clock rise while unselected");
   a_high_len: assert property (p_high_len) else $error("clock high too short");
   a_low_len:  assert property (p_low_len)  else $error("clock low too short");
   a_eight:    assert property (p_eight)    else $error("frame not eight clocks");
   a_stable:   assert property (p_stable)   else $error("data moved while clock high");

   c_dev_master:  cover property ($rose(ss_n_line) && dev_sck_oe);
   c_part_master: cover property ($rose(ss_n_line) && part_sck_oe);
   c_unsel:       cover property (!dev_sck_oe && ss_n_line && $past(ss_n_line));
endmodule

// [sim/ssc_device_tb_top.sv]
// Self-checking bench: device and partner joined over the link.
// Assumes the design files and the link interface are compiled first.
`include "ssc_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end

module ssc_device_tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   logic        core_clk, reset_n, spi_en, master_mode, tx_valid, tx_ready;
   logic        rx_valid, rx_ready, busy, part_master, p_tx_valid, p_tx_ready, p_rx_valid;
   logic [15:0] baud_div;
   logic [7:0]  tx_data, rx_data, p_tx_data, p_rx_data, mosi_sh, miso_sh;
   logic        sck_prev;
   int          n_errors = 0;
   int          n_checks = 0;
   int          n_prx = 0;

   ssc_link_if ssc_link_if_i ();
   ssc_device ssc_device_i (.core_clk(core_clk), .reset_n(reset_n), .spi_en(spi_en),
      .master_mode(master_mode), .baud_div(baud_div), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .busy(busy), .link(ssc_link_if_i));
   ssc_partner ssc_partner_i (.core_clk(core_clk), .reset_n(reset_n),
      .part_master(part_master), .p_tx_data(p_tx_data), .p_tx_valid(p_tx_valid),
      .p_tx_ready(p_tx_ready), .p_rx_data(p_rx_data), .p_rx_valid(p_rx_valid),
      .link(ssc_link_if_i));
   ssc_link_sva ssc_link_sva_i (.core_clk(core_clk), .reset_n(reset_n),
      .dev_sck_oe(ssc_link_if_i.dev_sck_oe), .dev_mosi_oe(ssc_link_if_i.dev_mosi_oe),
      .dev_miso_oe(ssc_link_if_i.dev_miso_oe), .part_sck_oe(ssc_link_if_i.part_sck_oe),
      .sck_line(ssc_link_if_i.sck_line), .mosi_line(ssc_link_if_i.mosi_line),
      .miso_line(ssc_link_if_i.miso_line), .ss_n_line(ssc_link_if_i.ss_n_line));

   // ==========================================================
   // Wire monitor: bits as seen at each clock rise, partner characters
   always @(posedge core_clk) begin
      sck_prev <= ssc_link_if_i.sck_line;
      if (ssc_link_if_i.sck_line && !sck_prev) begin
         mosi_sh <= {mosi_sh[6:0], ssc_link_if_i.mosi_line};
         miso_sh <= {miso_sh[6:0], ssc_link_if_i.miso_line};
      end
      if (p_rx_valid === 1'b1) begin
         n_prx <= n_prx + 1;
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #(`SSC_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end

   // ==========================================================
   // Shared tasks
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A wait that runs out counts as a mismatch and ends the run
   task automatic give_up(input string what);
      n_errors++;
      $display("BAD t=%0t %s timed out", $time, what);
      conclude();
   endtask

   task automatic push_dev(input logic [7:0] b);
      int k;
      @(posedge core_clk);
      tx_data  <= b;
      tx_valid <= 1'b1;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (tx_ready !== 1'b1 && k < 5000);
      if (tx_ready !== 1'b1) begin
         give_up("device push");
      end
      @(posedge core_clk);
      tx_valid <= 1'b0;
   endtask

   task automatic push_part(input logic [7:0] b);
      int k;
      @(posedge core_clk);
      p_tx_data  <= b;
      p_tx_valid <= 1'b1;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (p_tx_ready !== 1'b1 && k < 5000);
      if (p_tx_ready !== 1'b1) begin
         give_up("partner push");
      end
      @(posedge core_clk);
      p_tx_valid <= 1'b0;
   endtask

   // Steps off the edge first: a flag cleared at the calling edge still
   // reads high until that edge's updates have settled
   task automatic wait_rx();
      int k;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (rx_valid !== 1'b1 && k < 5000);
      if (rx_valid !== 1'b1) begin
         give_up("receive");
      end
   endtask

   task automatic take_rx();
      @(posedge core_clk);
      rx_ready <= 1'b1;
      @(posedge core_clk);
      rx_ready <= 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic idle_pins();
      @(posedge core_clk);
      spi_en      <= 1'b0;
      master_mode <= 1'b1;
      @(negedge core_clk);
      `CHK({ssc_link_if_i.dev_mosi_oe, ssc_link_if_i.dev_miso_oe}, 2'b00)
      @(posedge core_clk);
      spi_en      <= 1'b1;
      master_mode <= 1'b0;
      repeat (3) @(negedge core_clk);
      `CHK(ssc_link_if_i.dev_miso_oe, 1'b0)
      `CHK(ssc_link_if_i.dev_sck_oe, 1'b0)
   endtask

   task automatic xfer(input logic m, input logic [15:0] d, input logic [7:0] db,
                       input logic [7:0] pb);
      @(posedge core_clk);
      master_mode <= m;
      part_master <= ~m;
      baud_div    <= d;
      spi_en      <= 1'b1;
      if (m) begin
         push_part(pb);
         push_dev(db);
      end else begin
         push_dev(db);
         repeat (3) @(posedge core_clk);
         push_part(pb);
      end
      wait_rx();
      `CHK(rx_data, pb)
      repeat (3) @(negedge core_clk);
      `CHK(p_rx_data, db)
      `CHK(mosi_sh, m ? db : pb)
      `CHK(miso_sh, m ? pb : db)
      take_rx();
      @(negedge core_clk);
      `CHK(rx_valid, 1'b0)
   endtask

   task automatic fill_drain();
      int n;
      n = 0;
      @(posedge core_clk);
      spi_en   <= 1'b0;
      tx_valid <= 1'b1;
      tx_data  <= 8'h00;
      repeat (40) begin
         @(negedge core_clk);
         if (tx_ready !== 1'b1) break;
         @(posedge core_clk);
         n++;
         tx_data <= n[7:0];
      end
      @(posedge core_clk);
      tx_valid <= 1'b0;
      `CHK(n, 32)
      part_master <= 1'b0;
      p_tx_data   <= 8'h5a;
      p_tx_valid  <= 1'b1;
      baud_div    <= 16'h0004;
      @(posedge core_clk);
      master_mode <= 1'b1;
      spi_en      <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         wait_rx();
         repeat (20) @(negedge core_clk);
         `CHK(busy, 1'b0)
         `CHK(rx_data, 8'h5a)
         `CHK(p_rx_data, i[7:0])
         take_rx();
      end
      @(posedge core_clk);
      p_tx_valid <= 1'b0;
      // Four single exchanges and the 32 drained characters
      `CHK(n_prx, 36)
   endtask

   initial begin
      reset_n     = 1'b0;
      spi_en      = 1'b0;
      master_mode = 1'b0;
      baud_div    = 16'h0004;
      tx_data     = 8'h00;
      tx_valid    = 1'b0;
      rx_ready    = 1'b0;
      part_master = 1'b0;
      p_tx_data   = 8'h00;
      p_tx_valid  = 1'b0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      idle_pins();
      xfer(1'b1, 16'h0004, 8'ha5, 8'h3c);
      xfer(1'b0, 16'h0004, 8'h96, 8'hc3);
      xfer(1'b1, 16'h0006, 8'h80, 8'h01);
      xfer(1'b0, 16'h0004, 8'h01, 8'h80);
      fill_drain();
      conclude();
   end
endmodule
